/* rtl/nco_top.sv */
// Phase accumulator oscillator with byte-wide registers, output shaping and interrupt.
// ------------------------------------------------------------
// ------------------------------------------------------------
//
// The strobed register port and the register addresses were left to the implementer.
module nco_top (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // Register port
   input  wire nco_pkg::reg_req_s bus_req,
   output logic [7:0]            rdata,
   // Clock sources
   input  wire logic             fast_internal_osc,
   input  wire logic             logic_cell1_output,
   input  wire logic             logic_cell2_output,
   input  wire logic             logic_cell3_output,
   input  wire logic             logic_cell4_output,
   // Outputs
   output logic                  accum_carry_out,
   output logic                  nco_out,
   output logic                  pin_out,
   output logic                  pin_oe,
   output logic                  irq
);

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic rst_meta_r;
   logic rst_sync_n;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_r <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_n <= rst_meta_r;
      end
   end

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [nco_pkg::ACC_W-1:0] acc_r;
   logic [nco_pkg::ACC_W-1:0] inc_r;
   logic [nco_pkg::ACC_W-1:0] buf_r;
   logic [7:0]                ctrl_r;
   logic [7:0]                clk_ctrl_r;
   logic [7:0]                stat_r;
   logic [7:0]                int_en_r;
   logic                      pend_r;
   logic                      seen_r;
   logic                      load_now_r;
   logic                      carry_r;
   logic [nco_pkg::CNT_W-1:0] cnt_r;
   logic                      out_r;
   logic                      pin_r;
   logic                      oe_r;
   logic                      irq_r;
   logic [7:0]                rdata_r;
   logic                      tick;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire wr_w          = bus_req.wr;
   wire rd_w          = bus_req.rd;
   wire [3:0] addr_w  = bus_req.addr;
   wire [7:0] wd_w    = bus_req.wdata;
   wire en_w          = ctrl_r[nco_pkg::CTRL_EN_B];
   wire toggle_w      = ctrl_r[nco_pkg::CTRL_TOGGLE_B];
   wire pin_en_w      = ctrl_r[nco_pkg::CTRL_PIN_B];
   wire [2:0] src_w   = clk_ctrl_r[nco_pkg::CLK_SEL_LO +: 3];
   wire [2:0] pw_w    = clk_ctrl_r[nco_pkg::CLK_PW_LO +: nco_pkg::PW_W];
   wire acc_wr_w      = wr_w && (addr_w == nco_pkg::ACC_LOW_A || addr_w == nco_pkg::ACC_HIGH_A
                                 || addr_w == nco_pkg::ACC_UPPER_A);
   wire inc_wr_w      = wr_w && (addr_w == nco_pkg::INC_LOW_A || addr_w == nco_pkg::INC_HIGH_A
                                 || addr_w == nco_pkg::INC_UPPER_A);
   wire inc_low_wr_w  = wr_w && (addr_w == nco_pkg::INC_LOW_A);
   wire clr_wr_w      = wr_w && (addr_w == nco_pkg::INT_CLR_A);
   wire step_w        = tick && en_w;

   // ------------------------------------------------------------
   // Adder
   // ------------------------------------------------------------
   // Free-running full adder; its result only lands in the accumulator on a tick.
   wire [nco_pkg::ACC_W:0] sum_w = {1'b0, acc_r} + {1'b0, buf_r};

   function automatic logic [nco_pkg::ACC_W-1:0] put_byte(
      input logic [nco_pkg::ACC_W-1:0] cur,
      input logic [1:0]                idx,
      input logic [7:0]                val
   );
      logic [nco_pkg::ACC_W-1:0] res;
      res = cur;
      case (idx)
         2'h0:    res[7:0]   = val;
         2'h1:    res[15:8]  = val;
         default: res[19:16] = val[3:0];
      endcase
      return res;
   endfunction

   wire [1:0] acc_idx_w = (addr_w == nco_pkg::ACC_LOW_A)  ? 2'h0 :
                          (addr_w == nco_pkg::ACC_HIGH_A) ? 2'h1 : 2'h2;
   wire [1:0] inc_idx_w = (addr_w == nco_pkg::INC_LOW_A)  ? 2'h0 :
                          (addr_w == nco_pkg::INC_HIGH_A) ? 2'h1 : 2'h2;

   // Software writes take priority over a coincident addition.
   wire [nco_pkg::ACC_W-1:0] acc_nxt = acc_wr_w ? put_byte(acc_r, acc_idx_w, wd_w) :
                                       step_w   ? sum_w[nco_pkg::ACC_W-1:0] : acc_r;
   wire carry_nxt = step_w && !acc_wr_w && sum_w[nco_pkg::ACC_W];
   wire [nco_pkg::ACC_W-1:0] inc_nxt = inc_wr_w ? put_byte(inc_r, inc_idx_w, wd_w) : inc_r;

   // ------------------------------------------------------------
   // Increment buffer loading
   // ------------------------------------------------------------
   // The low-byte write arms a load on the second tick; high and upper must precede it.
   wire load_en_w = pend_r && seen_r && tick && en_w;
   wire pend_nxt  = (inc_low_wr_w && en_w) ? 1'b1 : (load_en_w || !en_w) ? 1'b0 : pend_r;
   wire seen_nxt  = (inc_low_wr_w && en_w) ? 1'b0 : (pend_r && tick) ? 1'b1 : seen_r;
   wire [nco_pkg::ACC_W-1:0] buf_nxt = (load_en_w || load_now_r) ? inc_r : buf_r;

   // ------------------------------------------------------------
   // Output shaping
   // ------------------------------------------------------------
   wire [nco_pkg::CNT_W-1:0] cnt_nxt =
      (carry_r && !toggle_w) ? ({1'b0, pw_w} + 4'h1) :
      (tick && cnt_r != 4'h0) ? cnt_r - 4'h1 : cnt_r;
   wire out_nxt = toggle_w ? (carry_r ? ~out_r : out_r) : (cnt_nxt != 4'h0);

   // ------------------------------------------------------------
   // Interrupt
   // ------------------------------------------------------------
   wire [7:0] set_w    = {7'h00, carry_r};
   wire [7:0] clr_w    = clr_wr_w ? wd_w : 8'h00;
   wire [7:0] stat_nxt = (stat_r & ~clr_w) | set_w;

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   // Increment reads show the written copy; the live buffer stays invisible.
   wire [7:0] rd_mux_w =
      (addr_w == nco_pkg::ACC_LOW_A)   ? acc_r[7:0] :
      (addr_w == nco_pkg::ACC_HIGH_A)  ? acc_r[15:8] :
      (addr_w == nco_pkg::ACC_UPPER_A) ? {4'h0, acc_r[19:16]} :
      (addr_w == nco_pkg::INC_LOW_A)   ? inc_r[7:0] :
      (addr_w == nco_pkg::INC_HIGH_A)  ? inc_r[15:8] :
      (addr_w == nco_pkg::INC_UPPER_A) ? {4'h0, inc_r[19:16]} :
      (addr_w == nco_pkg::CTRL_A)      ? ctrl_r :
      (addr_w == nco_pkg::CLK_CTRL_A)  ? clk_ctrl_r :
      (addr_w == nco_pkg::INT_STAT_A)  ? stat_r :
      (addr_w == nco_pkg::INT_EN_A)    ? int_en_r :
      (addr_w == nco_pkg::OUT_STATE_A) ? {5'h00, pin_r, out_r, carry_r} : 8'h00;

   // ------------------------------------------------------------
   // Clock source
   // ------------------------------------------------------------
   nco_clock_select u_clock_select (
      .clk                (clk),
      .rst_sync_n         (rst_sync_n),
      .fast_internal_osc  (fast_internal_osc),
      .logic_cell1_output (logic_cell1_output),
      .logic_cell2_output (logic_cell2_output),
      .logic_cell3_output (logic_cell3_output),
      .logic_cell4_output (logic_cell4_output),
      .clk_src_sel        (src_w),
      .input_tick         (tick)
   );

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         acc_r      <= nco_pkg::ACC_RST;
         inc_r      <= nco_pkg::ACC_RST;
         buf_r      <= nco_pkg::ACC_RST;
         ctrl_r     <= nco_pkg::BYTE_RST;
         clk_ctrl_r <= nco_pkg::BYTE_RST;
         int_en_r   <= nco_pkg::BYTE_RST;
         stat_r     <= nco_pkg::BYTE_RST;
         pend_r     <= 1'b0;
         seen_r     <= 1'b0;
         load_now_r <= 1'b0;
         carry_r    <= 1'b0;
         cnt_r      <= 4'h0;
         out_r      <= 1'b0;
         pin_r      <= 1'b0;
         oe_r       <= 1'b0;
         irq_r      <= 1'b0;
         rdata_r    <= 8'h00;
      end else begin
         acc_r      <= acc_nxt;
         inc_r      <= inc_nxt;
         buf_r      <= buf_nxt;
         ctrl_r     <= (wr_w && addr_w == nco_pkg::CTRL_A) ? wd_w : ctrl_r;
         clk_ctrl_r <= (wr_w && addr_w == nco_pkg::CLK_CTRL_A) ? wd_w : clk_ctrl_r;
         int_en_r   <= (wr_w && addr_w == nco_pkg::INT_EN_A) ? wd_w : int_en_r;
         stat_r     <= stat_nxt;
         pend_r     <= pend_nxt;
         seen_r     <= seen_nxt;
         load_now_r <= inc_wr_w && !en_w;
         carry_r    <= carry_nxt;
         cnt_r      <= cnt_nxt;
         out_r      <= out_nxt;
         pin_r      <= out_nxt && pin_en_w;
         oe_r       <= pin_en_w;
         irq_r      <= |(stat_nxt & int_en_r);
         rdata_r    <= rd_w ? rd_mux_w : 8'h00;
      end
   end

   assign accum_carry_out = carry_r;
   assign nco_out         = out_r;
   assign pin_out         = pin_r;
   assign pin_oe          = oe_r;
   assign irq             = irq_r;
   assign rdata           = rdata_r;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_acc_adds: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (step_w && !acc_wr_w) |=> (acc_r == $past(sum_w[19:0])))
      else $error("accumulator did not take the sum");

   a_carry_raw: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (step_w && !acc_wr_w && sum_w[20]) |=> accum_carry_out)
      else $error("overflow did not give a carry");

   // Back-to-back overflows are legal for large increments, so the drop is checked apart.
   a_carry_drops: assert property (@(posedge clk) disable iff (!rst_sync_n)
      !(step_w && !acc_wr_w && sum_w[20]) |=> !accum_carry_out)
      else $error("carry stood without an overflow");

   a_flag_sets: assert property (@(posedge clk) disable iff (!rst_sync_n)
      accum_carry_out |=> stat_r[0])
      else $error("overflow did not set the status flag");

   a_toggle_flips: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (accum_carry_out && toggle_w) |=> (nco_out != $past(nco_out)))
      else $error("toggle mode did not invert the output");

   a_pulse_high: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (accum_carry_out && !toggle_w) |=> nco_out)
      else $error("pulse mode did not raise the output");

   a_hold_off: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (!en_w && !acc_wr_w) |=> ($stable(acc_r) && !accum_carry_out))
      else $error("disabled accumulator moved");

   a_load_now: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (inc_wr_w && !en_w) |=> ##1 (buf_r == $past(inc_r)))
      else $error("disabled write did not reach the buffer");

   a_load_second: assert property (@(posedge clk) disable iff (!rst_sync_n)
      load_en_w |=> (buf_r == $past(inc_r)))
      else $error("armed load did not reach the buffer");

   a_read_inc: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (rd_w && addr_w == nco_pkg::INC_LOW_A) |=> (rdata == $past(inc_r[7:0])))
      else $error("increment read did not show the written value");

   a_irq_level: assert property (@(posedge clk) disable iff (!rst_sync_n)
      ##1 (irq == |(stat_r & $past(int_en_r))))
      else $error("interrupt output does not follow enabled status");

   a_flag_holds: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (stat_r[0] && !(clr_wr_w && wd_w[0])) |=> stat_r[0])
      else $error("status flag dropped without a clear");

   a_flag_clears: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (clr_wr_w && wd_w[0] && !accum_carry_out) |=> !stat_r[0])
      else $error("status flag survived a clear");

   a_pin_enable: assert property (@(posedge clk) disable iff (!rst_sync_n)
      pin_en_w |=> (pin_oe && (pin_out == nco_out)))
      else $error("enabled pin does not carry the output");

   a_pin_off: assert property (@(posedge clk) disable iff (!rst_sync_n)
      !pin_en_w |=> (!pin_oe && !pin_out))
      else $error("disabled pin is still driven");

   a_pulse_ends: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (!toggle_w && !carry_r && cnt_r == 4'h0) |=> !nco_out)
      else $error("pulse outlived its stretch count");

endmodule

/* rtl/nco_pkg.sv */
// Package with register map, field layout and bus carrier for the phase accumulator oscillator.
package nco_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int ACC_W  = 20;
   localparam int PW_W   = 3;
   localparam int CNT_W  = 4;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ACC_LOW_A    = 4'h0;
   localparam logic [ADDR_W-1:0] ACC_HIGH_A   = 4'h1;
   localparam logic [ADDR_W-1:0] ACC_UPPER_A  = 4'h2;
   localparam logic [ADDR_W-1:0] INC_LOW_A    = 4'h3;
   localparam logic [ADDR_W-1:0] INC_HIGH_A   = 4'h4;
   localparam logic [ADDR_W-1:0] INC_UPPER_A  = 4'h5;
   localparam logic [ADDR_W-1:0] CTRL_A       = 4'h6;
   localparam logic [ADDR_W-1:0] CLK_CTRL_A   = 4'h7;
   localparam logic [ADDR_W-1:0] INT_STAT_A   = 4'h8;
   localparam logic [ADDR_W-1:0] INT_CLR_A    = 4'h9;
   localparam logic [ADDR_W-1:0] INT_EN_A     = 4'hA;
   localparam logic [ADDR_W-1:0] OUT_STATE_A  = 4'hB;

   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int CTRL_EN_B     = 0;
   localparam int CTRL_TOGGLE_B = 1;
   localparam int CTRL_PIN_B    = 2;
   localparam int CLK_SEL_LO    = 0;
   localparam int CLK_PW_LO     = 5;
   localparam int STAT_OVF_B    = 0;
   localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;
   localparam logic [ACC_W-1:0]  ACC_RST  = 20'h00000;

   // ------------------------------------------------------------
   // Clock source codes
   // ------------------------------------------------------------
   localparam logic [2:0] SRC_FAST_OSC = 3'h0;
   localparam logic [2:0] SRC_SYS_CLK  = 3'h1;
   localparam logic [2:0] SRC_CELL1    = 3'h2;
   localparam logic [2:0] SRC_CELL2    = 3'h3;
   localparam logic [2:0] SRC_CELL3    = 3'h4;
   localparam logic [2:0] SRC_CELL4    = 3'h5;

   // ------------------------------------------------------------
   // Register bus request
   // ------------------------------------------------------------
   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } reg_req_s;

endpackage

/* rtl/nco_clock_select.sv */
// Input clock selector: synchronises the candidate sources and yields one tick per rising edge.
module nco_clock_select (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_sync_n,
   // Sources
   input  wire logic       fast_internal_osc,
   input  wire logic       logic_cell1_output,
   input  wire logic       logic_cell2_output,
   input  wire logic       logic_cell3_output,
   input  wire logic       logic_cell4_output,
   // Selection and result
   input  wire logic [2:0] clk_src_sel,
   output logic            input_tick
);

   logic [4:0] meta_r;
   logic [4:0] sync_r;
   logic       prev_r;
   logic       tick_r;
   wire  [4:0] raw_w = {logic_cell4_output, logic_cell3_output, logic_cell2_output,
                        logic_cell1_output, fast_internal_osc};
   wire        sel_level_w;
   wire        edge_w;

   // ------------------------------------------------------------
   // Selection
   // ------------------------------------------------------------
   // Sources faster than half the system clock alias; they are sampled, not used as clocks.
   assign sel_level_w = (clk_src_sel == nco_pkg::SRC_FAST_OSC) ? sync_r[0] :
                        (clk_src_sel == nco_pkg::SRC_CELL1)    ? sync_r[1] :
                        (clk_src_sel == nco_pkg::SRC_CELL2)    ? sync_r[2] :
                        (clk_src_sel == nco_pkg::SRC_CELL3)    ? sync_r[3] :
                        (clk_src_sel == nco_pkg::SRC_CELL4)    ? sync_r[4] : 1'b0;
   assign edge_w = (clk_src_sel == nco_pkg::SRC_SYS_CLK) ? 1'b1 : (sel_level_w & ~prev_r);

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         meta_r <= 5'h00;
         sync_r <= 5'h00;
         prev_r <= 1'b0;
         tick_r <= 1'b0;
      end else begin
         meta_r <= raw_w;
         sync_r <= meta_r;
         prev_r <= sel_level_w;
         tick_r <= edge_w;
      end
   end

   assign input_tick = tick_r;

endmodule

/* dv/nco_peripheral.sv */
// Model of the on-chip peripherals that consume the oscillator outputs.
module nco_peripheral (
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // Observed outputs
   input  wire logic accum_carry_out,
   input  wire logic nco_out,
   // Tallies
   output int        carry_cnt,
   output int        edge_cnt,
   output int        high_len
);
   timeunit 1ns;
   timeprecision 1ps;
   int   run_len;
   logic last_r;
   // Every edge is counted, so a toggle output can be matched against overflows.
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         carry_cnt = 0;
         edge_cnt  = 0;
         high_len  = 0;
         run_len   = 0;
         last_r    = 1'b0;
      end else begin
         if (accum_carry_out === 1'b1) carry_cnt++;
         if (nco_out !== last_r) edge_cnt++;
         if (nco_out === 1'b1) run_len++;
         if (nco_out === 1'b0 && last_r === 1'b1) begin
            high_len = run_len;
            run_len  = 0;
         end
         last_r = nco_out;
      end
   end
endmodule

/* dv/test_phase_accumulator_nco.sv */
// Self-checking bench of the phase accumulator oscillator.
module test_phase_accumulator_nco;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic              clk;
   logic              reset_n;
   nco_pkg::reg_req_s req;
   logic [7:0]        rdata;
   logic [4:0]        src;
   logic              carry, nco_out, pin_out, pin_oe, irq;
   int                carry_cnt, edge_cnt, high_len;
   int                error_cnt, tests_run, cyc;
   logic [7:0]        rd_v;
   logic [19:0]       acc_v;
   // ------------------------------------------------------------
   // Instances
   // ------------------------------------------------------------
   nco_top dut_u (.clk(clk), .reset_n(reset_n), .bus_req(req), .rdata(rdata),
      .fast_internal_osc(src[0]), .logic_cell1_output(src[1]), .logic_cell2_output(src[2]),
      .logic_cell3_output(src[3]), .logic_cell4_output(src[4]),
      .accum_carry_out(carry), .nco_out(nco_out), .pin_out(pin_out), .pin_oe(pin_oe),
      .irq(irq));
   nco_peripheral peri_u (.clk(clk), .reset_n(reset_n), .accum_carry_out(carry),
      .nco_out(nco_out), .carry_cnt(carry_cnt), .edge_cnt(edge_cnt), .high_len(high_len));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      req.wr    <= 1'b1;
      req.addr  <= a;
      req.wdata <= d;
      @(posedge clk);
      req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      req.rd   <= 1'b1;
      req.addr <= a;
      @(posedge clk);
      req.rd <= 1'b0;
      #1;
      rd_v = rdata;
   endtask
   task automatic set20(input logic [3:0] base, input logic [19:0] v);
      wr(base + 4'h2, {4'h0, v[19:16]});
      wr(base + 4'h1, v[15:8]);
      wr(base, v[7:0]);
   endtask
   task automatic get_acc();
      rd(nco_pkg::ACC_LOW_A);
      acc_v[7:0] = rd_v;
      rd(nco_pkg::ACC_HIGH_A);
      acc_v[15:8] = rd_v;
      rd(nco_pkg::ACC_UPPER_A);
      acc_v[19:16] = rd_v[3:0];
   endtask
   task automatic t_regs();
      for (int a = 0; a < 16; a++) begin
         rd(4'(a));
         chk("reset_or_unmapped", rd_v, 8'h00);
      end
      set20(nco_pkg::ACC_LOW_A, 20'hABCDE);
      get_acc();
      chk("acc_readback", acc_v, 20'hABCDE);
      wr(nco_pkg::INC_UPPER_A, 8'hFF);
      rd(nco_pkg::INC_UPPER_A);
      chk("inc_upper_bits", rd_v, 8'h0F);
      $display("test registers done");
   endtask
   task automatic t_sources();
      for (int k = 0; k < 5; k++) begin
         wr(nco_pkg::CTRL_A, 8'h00);
         set20(nco_pkg::ACC_LOW_A, 20'h00000);
         set20(nco_pkg::INC_LOW_A, 20'h00001);
         wr(nco_pkg::CLK_CTRL_A, (k == 0) ? 8'h00 : 8'(k + 1));
         wr(nco_pkg::CTRL_A, 8'h01);
         repeat (k + 3) begin
            @(posedge clk) src[k] <= 1'b1;
            repeat (4) @(posedge clk);
            src[k] <= 1'b0;
            repeat (4) @(posedge clk);
         end
         repeat (10) @(posedge clk);
         wr(nco_pkg::CTRL_A, 8'h00);
         get_acc();
         chk("ticks_per_source", acc_v, 20'(k + 3));
      end
      wr(nco_pkg::CLK_CTRL_A, 8'h06);
      wr(nco_pkg::CTRL_A, 8'h01);
      repeat (3) begin
         @(posedge clk) src <= 5'h1F;
         repeat (4) @(posedge clk);
         src <= 5'h00;
         repeat (4) @(posedge clk);
      end
      repeat (10) @(posedge clk);
      wr(nco_pkg::CTRL_A, 8'h00);
      get_acc();
      chk("unused_source_idle", acc_v, 20'h00007);
      $display("test sources done");
   endtask
   task automatic t_sysclk_irq();
      longint tot;
      int     c0;
      wr(nco_pkg::INT_EN_A, 8'h00);
      set20(nco_pkg::ACC_LOW_A, 20'h00000);
      set20(nco_pkg::INC_LOW_A, 20'h30001);
      wr(nco_pkg::CLK_CTRL_A, 8'h01);
      wr(nco_pkg::INT_CLR_A, 8'h01);
      c0 = carry_cnt;
      wr(nco_pkg::CTRL_A, 8'h01);
      repeat (50) @(posedge clk);
      wr(nco_pkg::CTRL_A, 8'h00);
      repeat (4) @(posedge clk);
      get_acc();
      tot = longint'(carry_cnt - c0) * 64'h100000 + longint'(acc_v);
      chk("carry_seen", 32'(carry_cnt > c0), 1);
      chk("sum_consistent", 32'(tot % 64'h30001), 0);
      chk("irq_masked", irq, 1'b0);
      rd(nco_pkg::INT_STAT_A);
      chk("status_set", rd_v, 8'h01);
      wr(nco_pkg::INT_EN_A, 8'h01);
      repeat (2) @(posedge clk);
      chk("irq_enabled", irq, 1'b1);
      wr(nco_pkg::INT_CLR_A, 8'h01);
      repeat (2) @(posedge clk);
      chk("irq_cleared", irq, 1'b0);
      $display("test overflow and interrupt done");
   endtask
   task automatic t_shape();
      int c0;
      int e0;
      set20(nco_pkg::INC_LOW_A, 20'h10000);
      wr(nco_pkg::CLK_CTRL_A, 8'h61);
      wr(nco_pkg::CTRL_A, 8'h01);
      repeat (70) @(posedge clk);
      wr(nco_pkg::CTRL_A, 8'h00);
      repeat (8) @(posedge clk);
      chk("pulse_width", high_len, 4);
      c0 = carry_cnt;
      e0 = edge_cnt;
      wr(nco_pkg::CTRL_A, 8'h07);
      repeat (70) @(posedge clk);
      chk("pin_enable", pin_oe, 1'b1);
      wr(nco_pkg::CTRL_A, 8'h06);
      repeat (8) @(posedge clk);
      chk("toggles", edge_cnt - e0, carry_cnt - c0);
      chk("toggle_level", nco_out, 32'((carry_cnt - c0) % 2));
      chk("pin_follows", pin_out, 32'((carry_cnt - c0) % 2));
      wr(nco_pkg::CTRL_A, 8'h00);
      repeat (2) @(posedge clk);
      chk("pin_released", {pin_oe, pin_out}, 2'b00);
      $display("test output shaping done");
   endtask
   task automatic t_buffer();
      logic [19:0] a0;
      set20(nco_pkg::ACC_LOW_A, 20'h00000);
      set20(nco_pkg::INC_LOW_A, 20'h00000);
      wr(nco_pkg::CTRL_A, 8'h01);
      wr(nco_pkg::INC_HIGH_A, 8'h10);
      repeat (20) @(posedge clk);
      get_acc();
      chk("no_load_without_low", acc_v, 20'h00000);
      wr(nco_pkg::INC_LOW_A, 8'h00);
      repeat (20) @(posedge clk);
      get_acc();
      chk("low_write_loads", 32'(acc_v != 0), 1);
      rd(nco_pkg::INC_HIGH_A);
      chk("inc_readback", rd_v, 8'h10);
      wr(nco_pkg::CTRL_A, 8'h00);
      get_acc();
      a0 = acc_v;
      repeat (20) @(posedge clk);
      get_acc();
      chk("frozen_when_off", acc_v, a0);
      $display("test increment buffer done");
   endtask
   // ------------------------------------------------------------
   // Run
   // ------------------------------------------------------------
   // The ceiling is over twenty times the expected run, so only a hang reaches it.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         print_verdict();
      end
   end
   initial begin
      reset_n   = 1'b0;
      req       = '0;
      src       = 5'h00;
      error_cnt = 0;
      tests_run = 0;
      cyc       = 0;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_regs();
      t_sources();
      t_sysclk_irq();
      t_shape();
      t_buffer();
      print_verdict();
   end
endmodule
